//--- mra_pkg.sv
package mra_pkg;

    // ----------------------------------------------------------------
    // Widths and constants
    // ----------------------------------------------------------------
    localparam int        DATA_W   = 8;      // Width of accumulator and memory byte.
    localparam int        MSB_POS  = 7;      // Bit that leaves on a left rotate.
    localparam int        LSB_POS  = 0;      // Bit that is filled on a left rotate.
    localparam logic [7:0] INC_STEP = 8'h01; // Increment amount.
    localparam logic [7:0] ACC_RST  = 8'h00; // Accumulator value after reset.
    localparam logic [7:0] ZERO_VAL = 8'h00; // Value that sets the zero flag.

    // ----------------------------------------------------------------
    // Operation selector
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        MRA_OP_NONE,
        MRA_OP_INCREMENT_TO_ACC,
        MRA_OP_COPY_MEM_TO_ACC,
        MRA_OP_COPY_ACC_TO_MEM,
        MRA_OP_BITWISE_OR_TO_ACC,
        MRA_OP_BITWISE_OR_TO_MEMORY,
        MRA_OP_ROTATE_LEFT_IN_PLACE,
        MRA_OP_ROTATE_LEFT_TO_ACC,
        MRA_OP_ROTATE_LEFT_VIA_CARRY,
        MRA_OP_ROTATE_LEFT_VIA_CARRY_TO_ACC
    } mra_op_e;

    // Request from decode: operation and the fetched memory byte.
    typedef struct packed {
        mra_op_e     op;
        logic [7:0]  mem_data;
    } mra_req_s;

    // Memory write-back carrier.
    typedef struct packed {
        logic        we;
        logic [7:0]  data;
    } mra_wr_s;

    // Status flag pair handled by this block.
    typedef struct packed {
        logic        zero;
        logic        carry;
    } mra_flags_s;

endpackage

//--- mra_alu.sv
`timescale 1ns/1ps
// Behaviour
// - Increment memory into accumulator, zero flag only.
// - Copy memory to accumulator, flags untouched.
// - Copy accumulator to memory, flags untouched.
// - OR into accumulator, zero flag only.
// - OR into memory, zero flag only.
// - Rotate memory left in place, no flags.
// - Rotate memory left into accumulator, no flags.
// - Rotate memory left through carry in place.
// - Rotate through carry into accumulator, carry updates.
module mra_alu
    import mra_pkg::*;
(
    input  wire logic        mclk_in,     // Core clock, 100 MHz.
    input  wire logic        rst_n_in,    // Synchronous reset, active low.
    input  wire mra_req_s    req_in,      // Operation and memory byte, one cycle.
    input  wire logic        carry_ld_in, // Load carry flag from core this cycle.
    input  wire logic        carry_val_in,// Carry value loaded by the core.
    output logic [7:0]       acc_out,     // Accumulator contents.
    output mra_flags_s       flags_out,   // Zero and carry flags.
    output mra_wr_s          mem_wr_out   // Memory write-back, strobe one cycle.
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0]  acc_r;        // Accumulator register.
    logic [7:0]  acc_nxt;      // Next accumulator.
    mra_flags_s  flags_r;      // Flag register.
    mra_flags_s  flags_nxt;    // Next flags.
    mra_wr_s     wr_r;         // Registered write-back.
    mra_wr_s     wr_nxt;       // Next write-back.
    logic [7:0]  m;            // Operand shorthand.
    logic [7:0]  or_res;       // OR result shared by two operations.
    logic [7:0]  inc_res;      // Increment result.
    logic [7:0]  rl_res;       // Plain left rotate.
    logic [7:0]  rlc_res;      // Left rotate through carry.

    // Every result is formed once from the operand and picked by the case below.
    // Sharing the OR path keeps both OR operations on one adder-free path.
    assign m       = req_in.mem_data;
    assign or_res  = acc_r | m;
    assign inc_res = m + INC_STEP;
    assign rl_res  = {m[MSB_POS-1:LSB_POS], m[MSB_POS]};
    assign rlc_res = {m[MSB_POS-1:LSB_POS], flags_r.carry};

    // ----------------------------------------------------------------
    // Next-state computation
    // ----------------------------------------------------------------
    // Only the operation in hand touches a destination; everything else holds.
    // A core carry load is applied first so an ALU carry update in the same
    // cycle wins, keeping the instruction's own effect.
    always_comb begin
        acc_nxt   = acc_r;
        flags_nxt = flags_r;
        wr_nxt    = '{we: 1'b0, data: wr_r.data};
        if (carry_ld_in) begin
            flags_nxt.carry = carry_val_in;
        end
        case (req_in.op)
            MRA_OP_INCREMENT_TO_ACC: begin
                acc_nxt        = inc_res;
                flags_nxt.zero = (inc_res == ZERO_VAL);
            end
            MRA_OP_COPY_MEM_TO_ACC: begin
                acc_nxt = m;
            end
            MRA_OP_COPY_ACC_TO_MEM: begin
                wr_nxt = '{we: 1'b1, data: acc_r};
            end
            MRA_OP_BITWISE_OR_TO_ACC: begin
                acc_nxt        = or_res;
                flags_nxt.zero = (or_res == ZERO_VAL);
            end
            MRA_OP_BITWISE_OR_TO_MEMORY: begin
                wr_nxt         = '{we: 1'b1, data: or_res};
                flags_nxt.zero = (or_res == ZERO_VAL);
            end
            MRA_OP_ROTATE_LEFT_IN_PLACE: begin
                wr_nxt = '{we: 1'b1, data: rl_res};
            end
            MRA_OP_ROTATE_LEFT_TO_ACC: begin
                acc_nxt = rl_res;
            end
            MRA_OP_ROTATE_LEFT_VIA_CARRY: begin
                wr_nxt          = '{we: 1'b1, data: rlc_res};
                flags_nxt.carry = m[MSB_POS];
            end
            MRA_OP_ROTATE_LEFT_VIA_CARRY_TO_ACC: begin
                acc_nxt         = rlc_res;
                flags_nxt.carry = m[MSB_POS];
            end
            // No operation or an unknown code changes nothing.
            default: begin
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // The reset is synchronous, so the reset branch only loads constants.
    // The write strobe clears on reset so no stray byte lands in memory.
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            acc_r   <= ACC_RST;
            flags_r <= '0;
            wr_r    <= '0;
        end else begin
            acc_r   <= acc_nxt;
            flags_r <= flags_nxt;
            wr_r    <= wr_nxt;
        end
    end

    // Outputs come straight from the registers, so decode never sees a glitch.
    assign acc_out    = acc_r;
    assign flags_out  = flags_r;
    assign mem_wr_out = wr_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    property p_inc;
        req_in.op == MRA_OP_INCREMENT_TO_ACC |=> acc_out == $past(m) + INC_STEP
            && !mem_wr_out.we && flags_out.zero == ($past(m) == 8'hff);
    endproperty
    a_inc: assert property (p_inc) else $error("increment result wrong");

    property p_mov_a;
        req_in.op == MRA_OP_COPY_MEM_TO_ACC && !carry_ld_in
            |=> acc_out == $past(m) && $stable(flags_out);
    endproperty
    a_mov_a: assert property (p_mov_a) else $error("copy to acc wrong");

    property p_mov_m;
        req_in.op == MRA_OP_COPY_ACC_TO_MEM && !carry_ld_in
            |=> mem_wr_out.we && mem_wr_out.data == $past(acc_out) && $stable(flags_out);
    endproperty
    a_mov_m: assert property (p_mov_m) else $error("copy to memory wrong");

    property p_or_a;
        req_in.op == MRA_OP_BITWISE_OR_TO_ACC
            |=> acc_out == ($past(acc_out) | $past(m)) && flags_out.zero == (acc_out == 8'h00);
    endproperty
    a_or_a: assert property (p_or_a) else $error("or to acc wrong");

    property p_or_m;
        req_in.op == MRA_OP_BITWISE_OR_TO_MEMORY |=> mem_wr_out.we
            && mem_wr_out.data == ($past(acc_out) | $past(m)) && $stable(acc_out);
    endproperty
    a_or_m: assert property (p_or_m) else $error("or to memory wrong");

    property p_rl;
        req_in.op == MRA_OP_ROTATE_LEFT_IN_PLACE && !carry_ld_in |=> mem_wr_out.we
            && mem_wr_out.data == {$past(m[6:0]), $past(m[7])} && $stable(flags_out);
    endproperty
    a_rl: assert property (p_rl) else $error("rotate in place wrong");

    property p_rla;
        req_in.op == MRA_OP_ROTATE_LEFT_TO_ACC && !carry_ld_in
            |=> acc_out == {$past(m[6:0]), $past(m[7])} && !mem_wr_out.we;
    endproperty
    a_rla: assert property (p_rla) else $error("rotate to acc wrong");

    property p_rlc;
        req_in.op == MRA_OP_ROTATE_LEFT_VIA_CARRY |=> mem_wr_out.data ==
            {$past(m[6:0]), $past(flags_out.carry)} && flags_out.carry == $past(m[7]);
    endproperty
    a_rlc: assert property (p_rlc) else $error("carry rotate wrong");

    property p_rlca;
        req_in.op == MRA_OP_ROTATE_LEFT_VIA_CARRY_TO_ACC |=> acc_out ==
            {$past(m[6:0]), $past(flags_out.carry)} && flags_out.carry == $past(m[7])
            && !mem_wr_out.we;
    endproperty
    a_rlca: assert property (p_rlca) else $error("carry rotate to acc wrong");

    property p_zero;
        req_in.op == MRA_OP_BITWISE_OR_TO_MEMORY
            |=> flags_out.zero == (mem_wr_out.data == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_zero_only;
        (req_in.op == MRA_OP_INCREMENT_TO_ACC || req_in.op == MRA_OP_BITWISE_OR_TO_ACC
            || req_in.op == MRA_OP_BITWISE_OR_TO_MEMORY) && !carry_ld_in
            |=> $stable(flags_out.carry);
    endproperty
    a_zero_only: assert property (p_zero_only) else $error("zero-only op moved carry");

    property p_rot_c_zero;
        req_in.op == MRA_OP_ROTATE_LEFT_VIA_CARRY
            || req_in.op == MRA_OP_ROTATE_LEFT_VIA_CARRY_TO_ACC |=> $stable(flags_out.zero);
    endproperty
    a_rot_c_zero: assert property (p_rot_c_zero) else $error("carry rotate moved zero");

    property p_acc_no_wr;
        req_in.op == MRA_OP_COPY_MEM_TO_ACC || req_in.op == MRA_OP_BITWISE_OR_TO_ACC
            |=> !mem_wr_out.we;
    endproperty
    a_acc_no_wr: assert property (p_acc_no_wr) else $error("acc op wrote memory");

    // Main scenarios that the bench is expected to reach.
    c_inc_wrap: cover property (req_in.op == MRA_OP_INCREMENT_TO_ACC && m == 8'hff);
    c_or_zero:  cover property (req_in.op == MRA_OP_BITWISE_OR_TO_ACC && or_res == 8'h00);
    c_rlc_b2b:  cover property (req_in.op == MRA_OP_ROTATE_LEFT_VIA_CARRY
                                ##1 req_in.op == MRA_OP_ROTATE_LEFT_VIA_CARRY);
    c_mov_wr:   cover property (req_in.op == MRA_OP_COPY_ACC_TO_MEM);

endmodule

//--- mra_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Data memory seen by decode, four bytes deep
// ----------------------------------------------------------------
module mra_mem_model
    import mra_pkg::*;
(
    input  wire logic       mclk_in,  // Core clock.
    input  wire logic [1:0] addr_in,  // Byte address held by decode.
    input  wire mra_wr_s    wr_in,    // Write-back from the datapath.
    output logic [7:0]      rd_out    // Byte fetched for the request.
);
    logic [7:0] mem_r [4];            // Storage, preset to known bytes.

    // Preset values give each rotate a set top bit somewhere.
    initial begin
        mem_r[0] = 8'h81;
        mem_r[1] = 8'hff;
        mem_r[2] = 8'h5a;
        mem_r[3] = 8'h40;
    end

    // Reads are combinational so the byte is ready in the request cycle.
    assign rd_out = mem_r[addr_in];

    // The address is still held in the strobe cycle, so the pair lands together.
    always @(posedge mclk_in) begin
        if (wr_in.we) begin
            mem_r[addr_in] <= wr_in.data;
        end
    end
endmodule

//--- test_move_or_rotate_alu_ops.sv
`timescale 1ns/1ps
module test_move_or_rotate_alu_ops;
    import mra_pkg::*;
    // ----------------------------------------------------------------
    // Signals and table
    // ----------------------------------------------------------------
    typedef struct packed {
        mra_op_e    op;   // Operation.
        logic [1:0] adr;  // Memory byte used.
        logic [7:0] acc;  // Expected accumulator.
        logic [1:0] zc;   // Expected zero and carry.
        logic [8:0] wr;   // Expected strobe and write data.
    } mra_row_s;
    logic        mclk_in, rst_n_in, carry_ld_in, carry_val_in; // Design inputs.
    mra_op_e     op_r;                  // Operation driven by decode.
    logic [1:0]  adr_r;                 // Address driven by decode.
    logic [7:0]  rd_w, acc_w;           // Fetched byte and accumulator.
    mra_flags_s  flg_w;                 // Flags seen.
    mra_wr_s     wr_w;                  // Write-back seen.
    int          err_total, num_checks; // Counters.
    // Rows run in order; each one leans on the state the one before left.
    mra_row_s rows [11] = '{
        '{MRA_OP_ROTATE_LEFT_VIA_CARRY,        2'h0, 8'h00, 2'h1, 9'h102},
        '{MRA_OP_ROTATE_LEFT_VIA_CARRY_TO_ACC, 2'h3, 8'h81, 2'h0, 9'h002},
        '{MRA_OP_INCREMENT_TO_ACC,             2'h1, 8'h00, 2'h2, 9'h002},
        '{MRA_OP_COPY_ACC_TO_MEM,              2'h2, 8'h00, 2'h2, 9'h100},
        '{MRA_OP_BITWISE_OR_TO_MEMORY,         2'h0, 8'h00, 2'h0, 9'h102},
        '{MRA_OP_BITWISE_OR_TO_ACC,            2'h2, 8'h00, 2'h2, 9'h002},
        '{MRA_OP_COPY_MEM_TO_ACC,              2'h1, 8'hff, 2'h2, 9'h002},
        '{MRA_OP_ROTATE_LEFT_IN_PLACE,         2'h3, 8'hff, 2'h2, 9'h180},
        '{MRA_OP_ROTATE_LEFT_TO_ACC,           2'h3, 8'h01, 2'h2, 9'h080},
        '{MRA_OP_ROTATE_LEFT_VIA_CARRY,        2'h3, 8'h01, 2'h3, 9'h100},
        '{MRA_OP_INCREMENT_TO_ACC,             2'h3, 8'h01, 2'h1, 9'h000}};

    mra_alu u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_in({op_r, rd_w}),
        .carry_ld_in(carry_ld_in), .carry_val_in(carry_val_in),
        .acc_out(acc_w), .flags_out(flg_w), .mem_wr_out(wr_w));
    mra_mem_model u_mem (.mclk_in(mclk_in), .addr_in(adr_r), .wr_in(wr_w), .rd_out(rd_w));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // One compare of accumulator, flags and write-back together.
    task automatic check(input string name, input logic [18:0] exp);
        num_checks++;
        if ({acc_w, flg_w, wr_w} !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, {acc_w, flg_w, wr_w});
        end
    endtask
    // Single place where the run ends.
    task close_out;
        $display("Counts: %0d errors in %0d checks", err_total, num_checks);
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and sequence
    // ----------------------------------------------------------------
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    // The sequence needs well under a thousand cycles.
    initial begin
        #20000;
        err_total++;
        close_out();
    end
    // Each row is taken at one edge and seen after the next.
    initial begin
        err_total = 0;
        num_checks = 0;
        {rst_n_in, carry_ld_in, carry_val_in, adr_r} = '0;
        op_r = MRA_OP_NONE;
        repeat (8) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        #1 check("reset", 19'h0);
        for (int i = 0; i < 11; i++) begin
            @(posedge mclk_in);
            op_r <= rows[i].op;
            adr_r <= rows[i].adr;
            @(posedge mclk_in);
            op_r <= MRA_OP_NONE;
            #1 check($sformatf("row %0d", i), {rows[i].acc, rows[i].zc, rows[i].wr});
        end
        // Core writes carry while idle; only carry moves.
        @(posedge mclk_in);
        carry_ld_in <= 1'b1;
        @(posedge mclk_in);
        carry_ld_in <= 1'b0;
        #1 check("carry load", {8'h01, 2'h0, 9'h000});
        // Rotate uses the old carry and beats a same-cycle load.
        @(posedge mclk_in);
        {carry_ld_in, carry_val_in} <= 2'b11;
        op_r <= MRA_OP_ROTATE_LEFT_VIA_CARRY_TO_ACC;
        adr_r <= 2'h0;
        @(posedge mclk_in);
        {carry_ld_in, carry_val_in} <= 2'b00;
        op_r <= MRA_OP_NONE;
        #1 check("carry clash", {8'h04, 2'h0, 9'h000});
        // Two carry rotates back to back; the second takes the carry the first left.
        // This decode model does not forward, so both read the byte as it stood.
        @(posedge mclk_in);
        op_r <= MRA_OP_ROTATE_LEFT_VIA_CARRY;
        adr_r <= 2'h1;
        @(posedge mclk_in);
        #1 check("chain first", {8'h04, 2'h1, 9'h1fe});
        @(posedge mclk_in);
        op_r <= MRA_OP_NONE;
        #1 check("chain second", {8'h04, 2'h1, 9'h1ff});
        @(posedge mclk_in);
        #1 check("strobe drops", {8'h04, 2'h1, 9'h0ff});
        // A reset in mid-run clears accumulator, flags and write-back again; memory keeps its bytes.
        @(posedge mclk_in);
        rst_n_in <= 1'b0;
        @(posedge mclk_in);
        rst_n_in <= 1'b1;
        #1 check("second reset", 19'h0);
        close_out();
    end
endmodule
